//--- hdl/tcs_pkg.sv
// Behaviour
// [R01] Bit 7 picks one 16-bit access via high buffer or two 8-bit bytes.
// [R02] Read-only bit 6 is 1 while the system clock comes from this oscillator.
// [R03] Two-bit prescale field divides the count clock by 1, 2, 4 or 8.
// [R04] Crystal oscillator runs only while its enable bit is 1, else fully off.
// [R05] External source: bit 2 low synchronises, high counts unsynchronised; ignored internally. Code synchronises both; bit 2 low only stops counting in sleep.
// [R06] Source bit 0 counts instruction clock Fosc/4; 1 counts external or oscillator edges.
// [R07] Counter increments only while the on bit is 1; clearing keeps the count.
// [R08] Timer, synchronous counter and asynchronous counter modes; external modes count rising edges.
// [R09] While enabled, both clock pins are forced inputs and read back as 0.
// [R10] Wide mode: high address is a buffer, loaded from live high on low reads.
// [R11] Wide mode: high writes fill buffer; low write loads all 16 bits at once.
// [R12] Wide mode: only low-byte writes clear the prescaler count.
// [R13] Oscillator keeps running in every power-managed mode once enabled.
// [R14] Count wraps from ffff to 0000 and sets the overflow flag and interrupt.
// [R15] With wide mode off, high and low bytes are read and written directly.
package tcs_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
	localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
	localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
	localparam logic [2:0] ADDR_PORT_READ = 3'h5;
	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTL_WIDE_ACCESS = 7;
	localparam int CTL_SYSCLK_STATUS = 6;
	localparam int CTL_PRESCALE_HI = 5;
	localparam int CTL_PRESCALE_LO = 4;
	localparam int CTL_OSC_ENABLE = 3;
	localparam int CTL_EXT_SYNC_DIS = 2;
	localparam int CTL_SOURCE_SEL = 1;
	localparam int CTL_COUNTER_ON = 0;
	localparam logic [7:0] CTL_WRITE_MASK = 8'hbf;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam int IRQ_OVERFLOW = 0;
	localparam logic [7:0] IRQ_IMPL_MASK = 8'h01;
	// ****************************************
	// Timing
	// ****************************************
	localparam int INSTR_CLK_DIV = 4;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	// Prescale codes
	typedef enum logic [1:0] {
		TCS_DIV1 = 2'b00,
		TCS_DIV2 = 2'b01,
		TCS_DIV4 = 2'b10,
		TCS_DIV8 = 2'b11
	} tcs_prescale_t;
endpackage

//--- hdl/tcs_tick_if.sv
`timescale 1ns/10ps
// Count tick path between core and prescaler
interface tcs_tick_if;
	logic tick_in;
	logic clear;
	tcs_pkg::tcs_prescale_t ratio;
	logic tick_out;
	modport core (output tick_in, output clear, output ratio, input tick_out);
	modport scaler (input tick_in, input clear, input ratio, output tick_out);
endinterface

//--- hdl/tcs_pin_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser with agreement filter and rise detect
module tcs_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_rise
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_q, level_d, rise_q, rise_d;

	// Level moves only when stages two and three agree
	always_comb begin
		level_d = level_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				level_d[i] = s3_q[i];
			end
		end
		rise_d = level_d & ~level_q;
	end

	// Stage one feeds stage two only
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			level_q <= '0;
			rise_q <= '0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
			rise_q <= rise_d;
		end
	end

	assign o_level = level_q;
	assign o_rise = rise_q;
endmodule

//--- hdl/tcs_prescaler.sv
`timescale 1ns/10ps
// Divide count ticks by 1, 2, 4 or 8
module tcs_prescaler (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	tcs_tick_if.scaler tick
);
	logic [2:0] cnt_q, cnt_d;
	logic out_q, out_d;
	logic [2:0] last;

	// Terminal count per ratio
	always_comb begin
		case (tick.ratio)
			tcs_pkg::TCS_DIV1: last = 3'h0;
			tcs_pkg::TCS_DIV2: last = 3'h1;
			tcs_pkg::TCS_DIV4: last = 3'h3;
			tcs_pkg::TCS_DIV8: last = 3'h7;
			default: last = 3'h0;
		endcase
		cnt_d = cnt_q;
		out_d = 1'b0;
		if (tick.clear) begin
			cnt_d = 3'h0; // [R12]
		end else if (tick.tick_in) begin
			if (cnt_q >= last) begin
				cnt_d = 3'h0;
				out_d = 1'b1; // [R03]
			end else begin
				cnt_d = cnt_q + 3'h1;
			end
		end
	end

	// Registered so the output is one clean pulse
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 3'h0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign tick.tick_out = out_q;
endmodule

//--- hdl/tcs_timer_top.sv
`timescale 1ns/10ps
module tcs_timer_top (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_ext_clock_pin,
	input wire logic i_osc_in_pin,
	input wire logic i_sysclk_from_osc,
	input wire logic i_sleep,
	input wire logic i_power_managed,
	input wire logic [1:0] i_port_dir,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_osc_enable,
	output logic [1:0] o_port_dir_eff
);
	// ****************************************
	// Input synchronisation
	// ****************************************
	logic [7:0] ctl_q, ctl_d;
	logic [2:0] pin_level, pin_rise;
	logic ext_src;

	// Oscillator output replaces the pin while the crystal runs
	assign ext_src = ctl_q[tcs_pkg::CTL_OSC_ENABLE] ? i_osc_in_pin : i_ext_clock_pin; // [R06]

	tcs_pin_sync #(.WIDTH(3)) u_sync (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_pin({i_sysclk_from_osc, i_ext_clock_pin, ext_src}),
		.o_level(pin_level),
		.o_rise(pin_rise)
	);

	// ****************************************
	// Instruction clock divider
	// ****************************************
	logic [1:0] div_q, div_d;
	logic instr_en;

	// Fosc/4 as a one-cycle enable
	always_comb begin
		div_d = div_q + 2'h1;
		instr_en = (div_q == 2'(tcs_pkg::INSTR_CLK_DIV - 1)); // [R06]
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_d;
		end
	end

	// ****************************************
	// Count source and prescaler
	// ****************************************
	tcs_tick_if tick ();
	logic raw_tick, wr_low, wr_high, rd_low, is_wide;

	assign is_wide = ctl_q[tcs_pkg::CTL_WIDE_ACCESS];
	assign wr_low = i_wr && (i_addr == tcs_pkg::ADDR_COUNT_LOW);
	assign wr_high = i_wr && (i_addr == tcs_pkg::ADDR_COUNT_HIGH);
	assign rd_low = i_rd && (i_addr == tcs_pkg::ADDR_COUNT_LOW);

	// Sync mode follows the core clock, which stops in sleep; async keeps counting
	always_comb begin
		if (!ctl_q[tcs_pkg::CTL_SOURCE_SEL]) begin
			raw_tick = instr_en; // [R05] [R08]
		end else if (ctl_q[tcs_pkg::CTL_EXT_SYNC_DIS]) begin
			raw_tick = pin_rise[0]; // [R05] [R08]
		end else begin
			raw_tick = pin_rise[0] && !i_sleep; // [R05] [R08]
		end
	end

	assign tick.tick_in = raw_tick && ctl_q[tcs_pkg::CTL_COUNTER_ON]; // [R07]
	assign tick.clear = wr_low || (wr_high && !is_wide); // [R12]
	assign tick.ratio = tcs_pkg::tcs_prescale_t'(
		ctl_q[tcs_pkg::CTL_PRESCALE_HI:tcs_pkg::CTL_PRESCALE_LO]); // [R03]

	tcs_prescaler u_presc (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.tick(tick.core)
	);

	// ****************************************
	// Control and counter registers
	// ****************************************
	logic [15:0] count_q, count_d;
	logic [7:0] hbuf_q, hbuf_d;
	logic [7:0] status_q, status_d, mask_q, mask_d;
	logic ovf;

	// Writes win over a coincident increment
	always_comb begin
		ctl_d = ctl_q;
		count_d = count_q;
		hbuf_d = hbuf_q;
		mask_d = mask_q;
		ovf = 1'b0;
		if (tick.tick_out && ctl_q[tcs_pkg::CTL_COUNTER_ON]) begin
			count_d = count_q + 16'h0001; // [R07]
			ovf = (count_q == tcs_pkg::COUNT_MAX); // [R14]
		end
		if (i_wr && i_addr == tcs_pkg::ADDR_CONTROL) begin
			ctl_d = i_wdata & tcs_pkg::CTL_WRITE_MASK;
		end
		if (i_wr && i_addr == tcs_pkg::ADDR_IRQ_MASK) begin
			mask_d = i_wdata & tcs_pkg::IRQ_IMPL_MASK;
		end
		if (wr_low) begin
			if (is_wide) begin
				count_d = {hbuf_q, i_wdata}; // [R11]
			end else begin
				count_d = {count_q[15:8], i_wdata}; // [R15]
			end
			ovf = 1'b0;
		end
		if (wr_high) begin
			if (is_wide) begin
				hbuf_d = i_wdata; // [R11]
			end else begin
				count_d = {i_wdata, count_q[7:0]}; // [R15]
				ovf = 1'b0;
			end
		end
		if (rd_low && is_wide) begin
			hbuf_d = count_q[15:8]; // [R10]
		end
		// Status bit follows the system clock switch, never written
		ctl_d[tcs_pkg::CTL_SYSCLK_STATUS] = pin_level[2]; // [R02]
	end

	// Set wins over write-one-to-clear
	always_comb begin
		status_d = status_q;
		if (i_wr && i_addr == tcs_pkg::ADDR_IRQ_STATUS) begin
			status_d = status_q & ~i_wdata;
		end
		if (ovf) begin
			status_d[tcs_pkg::IRQ_OVERFLOW] = 1'b1; // [R14]
		end
		status_d = status_d & tcs_pkg::IRQ_IMPL_MASK;
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_q <= tcs_pkg::CONTROL_RESET;
			count_q <= 16'h0000;
			hbuf_q <= 8'h00;
			status_q <= 8'h00;
			mask_q <= 8'h00;
		end else begin
			ctl_q <= ctl_d;
			count_q <= count_d;
			hbuf_q <= hbuf_d;
			status_q <= status_d;
			mask_q <= mask_d;
		end
	end

	// ****************************************
	// Read data, interrupt and pin control
	// ****************************************
	logic [7:0] rdata_q, rdata_d;
	logic irq_q, irq_d, osc_q, osc_d;
	logic [1:0] dir_q, dir_d;
	logic timer_on;

	assign timer_on = ctl_q[tcs_pkg::CTL_COUNTER_ON];

	// Data valid only in the cycle after the read strobe
	always_comb begin
		rdata_d = 8'h00;
		if (i_rd) begin
			case (i_addr)
				tcs_pkg::ADDR_CONTROL: rdata_d = ctl_q; // [R01] [R02]
				tcs_pkg::ADDR_COUNT_LOW: rdata_d = count_q[7:0];
				tcs_pkg::ADDR_COUNT_HIGH: rdata_d = is_wide ? hbuf_q : count_q[15:8]; // [R10] [R15]
				tcs_pkg::ADDR_IRQ_STATUS: rdata_d = status_q;
				tcs_pkg::ADDR_IRQ_MASK: rdata_d = mask_q;
				tcs_pkg::ADDR_PORT_READ: rdata_d = timer_on ? 8'h00 :
					{6'h00, pin_level[1], ext_src_lvl(pin_level)}; // [R09]
				default: rdata_d = 8'h00;
			endcase
		end
		irq_d = |(status_d & mask_d); // [R14]
		// Power-managed state deliberately has no say here
		osc_d = ctl_d[tcs_pkg::CTL_OSC_ENABLE] || (1'b0 && i_power_managed); // [R04] [R13]
		dir_d = (ctl_d[tcs_pkg::CTL_COUNTER_ON]) ? 2'b11 : i_port_dir; // [R09]
	end

	// Port read of the oscillator input pin uses the selected source level
	function automatic logic ext_src_lvl(input logic [2:0] lvl);
		ext_src_lvl = lvl[0];
	endfunction

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
			osc_q <= 1'b0;
			dir_q <= 2'b11;
		end else begin
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			osc_q <= osc_d;
			dir_q <= dir_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_irq = irq_q;
	assign o_osc_enable = osc_q;
	assign o_port_dir_eff = dir_q;
endmodule

//--- testbench/tcs_ext_src.sv
`timescale 1ns/10ps
// ****
// Far-side clock sources
// ****
module tcs_ext_src (
	input wire logic i_core_clk,
	input wire logic i_run,
	output logic o_pin,
	output logic o_osc
);
	logic [4:0] cnt_q;
	// Phase counter; both lines rest low between bursts
	always_ff @(posedge i_core_clk) begin
		if (!i_run) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	// Pin rises every 16 cycles, crystal every 32
	assign o_pin = cnt_q[3];
	assign o_osc = cnt_q[4];
endmodule

//--- testbench/tcs_timer_asserts.sv
`timescale 1ns/10ps
// ****
// Port checker
// ****
module tcs_timer_asserts (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_irq,
	input wire logic o_osc_enable,
	input wire logic [1:0] o_port_dir_eff
);
	logic [7:0] ctl_q;
	logic [7:0] ctl_d;
	// Shadow of the control register as software wrote it
	always_comb begin
		ctl_d = ctl_q;
		if (i_wr && i_addr == tcs_pkg::ADDR_CONTROL) begin
			ctl_d = i_wdata;
		end
	end
	// Shadow register
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_q <= 8'h00;
		end else begin
			ctl_q <= ctl_d;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	ctl_readback_a: assert property (i_rd && i_addr == tcs_pkg::ADDR_CONTROL |=>
		{o_rdata[7], o_rdata[5:0]} == {$past(ctl_q[7]), $past(ctl_q[5:0])})
		else $error("control readback wrong");
	osc_follow_a: assert property ($stable(ctl_q[3]) |-> o_osc_enable == ctl_q[3])
		else $error("oscillator enable wrong");
	pins_input_a: assert property (ctl_q[0] && $past(ctl_q[0]) |-> o_port_dir_eff == 2'h3)
		else $error("pins not inputs");
	port_zero_a: assert property (i_rd && i_addr == tcs_pkg::ADDR_PORT_READ && ctl_q[0]
		|=> o_rdata == 8'h00) else $error("port read not zero");
	unmapped_read_a: assert property (i_rd && i_addr > 3'h5 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	mask_off_a: assert property (i_wr && i_addr == tcs_pkg::ADDR_IRQ_MASK && !i_wdata[0]
		|=> !o_irq) else $error("masked irq high");
	irq_clear_a: assert property (i_wr && i_addr == tcs_pkg::ADDR_IRQ_STATUS && i_wdata[0]
		|=> !o_irq) else $error("irq not cleared");
	irq_bits_a: assert property (i_rd && i_addr inside {3'h3, 3'h4} |=> o_rdata[7:1] == 7'h00)
		else $error("reserved irq bits set");
endmodule
bind tcs_timer_top tcs_timer_asserts u_tcs_timer_asserts (.i_core_clk, .i_reset_n, .i_addr,
	.i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .o_osc_enable, .o_port_dir_eff);

//--- testbench/tcs_timer_top_test.sv
`timescale 1ns/10ps
module tcs_timer_top_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b0;
	logic sysclk = 1'b0;
	logic pm = 1'b0;
	logic pin;
	logic osc;
	logic [7:0] rdata;
	logic irq;
	logic [1:0] dir_eff;
	logic osc_en;
	logic [7:0] got;
	logic [7:0] modes [3] = '{8'h03, 8'h07, 8'h0b};
	logic [7:0] exps [3] = '{8'h0a, 8'h0a, 8'h05};
	int errors = 0;
	int n_checks = 0;
	// 10 MHz core clock
	always #50 clk = ~clk;
	tcs_ext_src u_tcs_ext_src (.i_core_clk(clk), .i_run(run), .o_pin(pin), .o_osc(osc));
	tcs_timer_top u_tcs_timer_top (.i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_ext_clock_pin(pin), .i_osc_in_pin(osc),
		.i_sysclk_from_osc(sysclk), .i_sleep(1'b0), .i_power_managed(pm),
		.i_port_dir(2'h1), .o_rdata(rdata), .o_irq(irq), .o_osc_enable(osc_en),
		.o_port_dir_eff(dir_eff));
	// ****
	// Bus tasks
	// ****
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] tol = 8'h00);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
		if (got >= e - tol && got <= e + tol) begin
			chk(got, got);
		end else begin
			chk(got, e);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard, several times the expected run
	initial begin
		repeat (8000) @(posedge clk);
		errors++;
		final_report;
	end
	// ****
	// Tests
	// ****
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(tcs_pkg::ADDR_CONTROL, 8'h00);
		sysclk <= 1'b1;
		repeat (6) @(posedge clk);
		wr_reg(tcs_pkg::ADDR_CONTROL, 8'hbe);
		rd_chk(tcs_pkg::ADDR_CONTROL, 8'hfe);
		sysclk <= 1'b0;
		repeat (6) @(posedge clk);
		rd_chk(tcs_pkg::ADDR_CONTROL, 8'hbe);
		// Buffered high byte, then direct bytes
		wr_reg(tcs_pkg::ADDR_CONTROL, 8'h80);
		wr_reg(tcs_pkg::ADDR_COUNT_HIGH, 8'h5a);
		wr_reg(tcs_pkg::ADDR_COUNT_LOW, 8'h3c);
		wr_reg(tcs_pkg::ADDR_COUNT_HIGH, 8'ha5);
		rd_chk(tcs_pkg::ADDR_COUNT_LOW, 8'h3c);
		rd_chk(tcs_pkg::ADDR_COUNT_HIGH, 8'h5a);
		wr_reg(tcs_pkg::ADDR_CONTROL, 8'h00);
		rd_chk(tcs_pkg::ADDR_COUNT_HIGH, 8'h5a);
		wr_reg(tcs_pkg::ADDR_COUNT_HIGH, 8'h77);
		rd_chk(tcs_pkg::ADDR_COUNT_HIGH, 8'h77);
		rd_chk(tcs_pkg::ADDR_COUNT_LOW, 8'h3c);
		// Instruction clock through each prescale code; phase allows one count slack
		for (int c = 0; c < 4; c++) begin
			wr_reg(tcs_pkg::ADDR_COUNT_LOW, 8'h00);
			wr_reg(tcs_pkg::ADDR_COUNT_HIGH, 8'h00);
			wr_reg(tcs_pkg::ADDR_CONTROL, {2'h0, c[1:0], 4'h1});
			repeat (160) @(posedge clk);
			wr_reg(tcs_pkg::ADDR_CONTROL, 8'h00);
			rd_chk(tcs_pkg::ADDR_COUNT_LOW, 8'h28 >> c, 8'h01);
			repeat (20) @(posedge clk);
			rd_chk(tcs_pkg::ADDR_COUNT_LOW, got);
		end
		// External pin synchronised, then unsynchronised, then crystal, all in power-managed mode
		pm <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			wr_reg(tcs_pkg::ADDR_COUNT_LOW, 8'h00);
			wr_reg(tcs_pkg::ADDR_COUNT_HIGH, 8'h00);
			wr_reg(tcs_pkg::ADDR_CONTROL, modes[m]);
			chk({7'h00, osc_en}, {7'h00, modes[m][3]});
			run <= 1'b1;
			repeat (160) @(posedge clk);
			run <= 1'b0;
			rd_chk(tcs_pkg::ADDR_PORT_READ, 8'h00);
			chk({6'h00, dir_eff}, 8'h03);
			repeat (12) @(posedge clk);
			wr_reg(tcs_pkg::ADDR_CONTROL, 8'h00);
			rd_chk(tcs_pkg::ADDR_COUNT_LOW, exps[m]);
			chk({6'h00, dir_eff}, 8'h01);
		end
		// Overflow, mask and clear
		wr_reg(tcs_pkg::ADDR_IRQ_MASK, 8'h01);
		wr_reg(tcs_pkg::ADDR_CONTROL, 8'h80);
		wr_reg(tcs_pkg::ADDR_COUNT_HIGH, 8'hff);
		wr_reg(tcs_pkg::ADDR_COUNT_LOW, 8'hfe);
		wr_reg(tcs_pkg::ADDR_CONTROL, 8'h81);
		repeat (20) @(posedge clk);
		rd_chk(tcs_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk({7'h00, irq}, 8'h01);
		// Low read loads the buffer with the wrapped high byte
		rd_chk(tcs_pkg::ADDR_COUNT_LOW, 8'h04, 8'h04);
		rd_chk(tcs_pkg::ADDR_COUNT_HIGH, 8'h00);
		wr_reg(tcs_pkg::ADDR_IRQ_MASK, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr_reg(tcs_pkg::ADDR_IRQ_MASK, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wr_reg(tcs_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk({7'h00, irq}, 8'h00);
		rd_chk(tcs_pkg::ADDR_IRQ_STATUS, 8'h00);
		wr_reg(3'h7, 8'hff);
		rd_chk(3'h7, 8'h00);
		final_report;
	end
endmodule
